// file: verilog/btc_pkg.sv
// Shared constants and types of the block transfer controller.
// Assumes a 24-bit system address space and a 32-bit memory data path.
package btc_pkg;

	// ****************************************
	// Register information in system memory
	// ****************************************
	localparam logic [23:0] BTC_INFO_BASE   = 24'hfff800;
	localparam logic [23:0] BTC_INFO_STRIDE = 24'h000010;

	// ****************************************
	// Bus register offsets
	// ****************************************
	localparam logic [7:0] BTC_OFS_CTRL    = 8'h00;
	localparam logic [7:0] BTC_OFS_ENABLE  = 8'h04;
	localparam logic [7:0] BTC_OFS_SWREQ   = 8'h08;
	localparam logic [7:0] BTC_OFS_STATUS  = 8'h0c;
	localparam logic [7:0] BTC_OFS_INT_CLR = 8'h10;
	localparam logic [7:0] BTC_OFS_INT_EN  = 8'h14;
	localparam logic [7:0] BTC_OFS_STATE   = 8'h18;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int         BTC_CTRL_STOP = 0;
	localparam logic       BTC_STOP_RST  = 1'b1;
	localparam int         BTC_SW_GO     = 7;
	localparam int         BTC_ST_END    = 0;
	localparam int         BTC_ST_BLK    = 1;
	localparam logic [1:0] BTC_STATUS_RST = 2'h0;
	localparam logic [1:0] BTC_INTEN_RST  = 2'h0;

	// Mode A: source mode, destination mode, transfer mode, side, size
	localparam int BTC_MA_SM  = 6;
	localparam int BTC_MA_DM  = 4;
	localparam int BTC_MA_MD  = 2;
	localparam int BTC_MA_DTS = 1;
	localparam int BTC_MA_SZ  = 0;
	// Mode B: interrupt after every transfer when set
	localparam int BTC_MB_DISEL = 6;

	localparam logic [1:0] BTC_MD_BLOCK = 2'b10;
	localparam logic [1:0] BTC_AM_INC   = 2'b10;
	localparam logic [1:0] BTC_AM_DEC   = 2'b11;

	localparam logic [1:0] BTC_SZ_BYTE = 2'b00;
	localparam logic [1:0] BTC_SZ_WORD = 2'b01;
	localparam logic [1:0] BTC_SZ_LONG = 2'b10;

	localparam logic [1:0] BTC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] BTC_RESP_DECERR = 2'b11;

	typedef enum logic [2:0] {
		BTC_S_IDLE  = 3'b000,
		BTC_S_FETCH = 3'b001,
		BTC_S_READ  = 3'b010,
		BTC_S_WRITE = 3'b011,
		BTC_S_BACK  = 3'b100
	} btc_state_t;

endpackage : btc_pkg

// file: verilog/btc_trig_if.sv
// Request path between the edge detector and the sequencer.
// Assumes both ends run on the same clock.
interface btc_trig_if #(
	parameter int N_SRC = 8
) ();
	localparam int IW = $clog2(N_SRC);

	logic [N_SRC-1:0] en;
	logic [N_SRC-1:0] pend;
	logic             take;
	logic [IW-1:0]    take_idx;

	modport ctl (output en, output take, output take_idx, input pend);
	modport det (input en, input take, input take_idx, output pend);
endinterface : btc_trig_if

// file: verilog/btc_trigger.sv
// Falling-edge detector with per-source pending flags.
// Assumes request inputs are synchronous and idle high.
module btc_trigger
	import btc_pkg::*;
#(
	parameter int N_SRC = 8
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Request pins
	input  wire logic [N_SRC-1:0] ext_req,
	// Sequencer side
	btc_trig_if.det               tif
);

	typedef struct packed {
		logic [N_SRC-1:0] prev;
		logic [N_SRC-1:0] pend;
	} btc_trig_t;

	btc_trig_t s_r;
	btc_trig_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = ext_req;
		for (int i = 0; i < N_SRC; i++) begin
			// A new edge in the taking cycle stays pending
			if (tif.take && (int'(tif.take_idx) == i)) begin
				s_nxt.pend[i] = 1'b0;
			end
			if (s_r.prev[i] && !ext_req[i] && tif.en[i]) begin
				s_nxt.pend[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r.prev <= '1;
			s_r.pend <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tif.pend = s_r.pend;

endmodule : btc_trigger

// file: verilog/btc_transfer_controller.sv
// Block transfer controller: sequencer, register file and bus slave.
// Assumes a memory port that acks each request with one-cycle mem_ack.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
module btc_transfer_controller
	import btc_pkg::*;
#(
	parameter int N_SRC = 8
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Request pins
	input  wire logic [N_SRC-1:0] ext_req,
	// Register bus, AXI4-Lite
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output      logic             s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output      logic             s_axi_wready,
	output      logic [1:0]       s_axi_bresp,
	output      logic             s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output      logic             s_axi_arready,
	output      logic [31:0]      s_axi_rdata,
	output      logic [1:0]       s_axi_rresp,
	output      logic             s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// System memory port
	output      logic             mem_req,
	output      logic             mem_we,
	output      logic [1:0]       mem_size,
	output      logic [23:0]      mem_addr,
	output      logic [31:0]      mem_wdata,
	input  wire logic [31:0]      mem_rdata,
	input  wire logic             mem_ack,
	// Interrupt
	output      logic             irq
);

	localparam int IW = $clog2(N_SRC);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		btc_state_t       st;
		logic [1:0]       wcnt;
		logic [IW-1:0]    idx;
		logic             from_sw;
		logic [7:0]       transfer_mode_a;
		logic [7:0]       transfer_mode_b;
		logic [23:0]      source_pointer;
		logic [23:0]      destination_pointer;
		logic [23:0]      blk_start;
		logic [15:0]      unit_count;
		logic [15:0]      block_count;
		logic [15:0]      data;
		logic             fin;
		logic             cpu_irq;
		logic             mem_req;
		logic             mem_we;
		logic [1:0]       mem_size;
		logic [23:0]      mem_addr;
		logic [31:0]      mem_wdata;
		logic             stop;
		logic [N_SRC-1:0] en;
		logic             sw_pend;
		logic [IW-1:0]    sw_idx;
		logic [1:0]       status;
		logic [1:0]       inten;
		logic             irq;
		logic             take;
		logic [IW-1:0]    take_idx;
		logic             awready;
		logic             wready;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       awaddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} btc_main_t;

	btc_main_t s_r;
	btc_main_t s_nxt;

	btc_trig_if #(.N_SRC(N_SRC)) tif ();

	btc_trigger #(.N_SRC(N_SRC)) u_trigger (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ext_req (ext_req),
		.tif     (tif.det)
	);

	assign tif.en       = s_r.en;
	assign tif.take     = s_r.take;
	assign tif.take_idx = s_r.take_idx;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : wmerge

	function automatic logic [23:0] step_addr(input logic [23:0] a,
		input logic [1:0] am, input logic word);
		logic [23:0] d;
		d = word ? 24'h000002 : 24'h000001;
		case (am)
			BTC_AM_INC: step_addr = a + d;
			BTC_AM_DEC: step_addr = a - d;
			default:    step_addr = a;
		endcase
	endfunction : step_addr

	function automatic logic [23:0] info_addr(input logic [IW-1:0] i,
		input logic [1:0] w);
		info_addr = 24'(BTC_INFO_BASE + 24'(i) * BTC_INFO_STRIDE
			+ {20'h00000, w, 2'b00});
	endfunction : info_addr

	function automatic logic [32:0] reg_read(input logic [7:0] a,
		input btc_main_t s);
		// Top bit flags a decoded address
		case (a)
			BTC_OFS_CTRL:    reg_read = {1'b1, 31'h0, s.stop};
			BTC_OFS_ENABLE:  reg_read = {1'b1, 32'(s.en)};
			BTC_OFS_SWREQ:   reg_read = {1'b1, 24'h0, s.sw_pend,
				7'(s.sw_idx)};
			BTC_OFS_STATUS:  reg_read = {1'b1, 30'h0, s.status};
			BTC_OFS_INT_CLR: reg_read = {1'b1, 32'h0};
			BTC_OFS_INT_EN:  reg_read = {1'b1, 30'h0, s.inten};
			BTC_OFS_STATE:   reg_read = {1'b1, 16'h0, 8'(s.idx),
				4'h0, s.from_sw, s.st};
			default:         reg_read = {1'b0, 32'h0};
		endcase
	endfunction : reg_read

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [1:0]  sset;
		logic        word;
		logic [32:0] rd;
		logic [31:0] wv;
		logic        found;
		logic [IW-1:0] pick;
		sset  = 2'h0;
		word  = 1'b0;
		rd    = 33'h0;
		wv    = 32'h0;
		found = 1'b0;
		pick  = '0;
		s_nxt = s_r;
		s_nxt.take = 1'b0;
		word = s_r.transfer_mode_a[BTC_MA_SZ];

		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (tif.pend[i] && s_r.en[i]) begin
				found = 1'b1;
				pick  = IW'(i);
			end
		end

		// Sequencer; each access drops req for a cycle after its ack
		case (s_r.st)
			BTC_S_IDLE: begin
				if (!s_r.stop) begin
					if (found && !s_r.take) begin
						s_nxt.idx      = pick;
						s_nxt.from_sw  = 1'b0;
						s_nxt.take     = 1'b1;
						s_nxt.take_idx = pick;
						s_nxt.wcnt     = 2'd0;
						s_nxt.st       = BTC_S_FETCH;
					end else if (s_r.sw_pend) begin
						s_nxt.idx     = s_r.sw_idx;
						s_nxt.from_sw = 1'b1;
						s_nxt.sw_pend = 1'b0;
						s_nxt.wcnt    = 2'd0;
						s_nxt.st      = BTC_S_FETCH;
					end
				end
			end
			BTC_S_FETCH: begin
				if (!s_r.mem_req) begin
					s_nxt.mem_req  = 1'b1;
					s_nxt.mem_we   = 1'b0;
					s_nxt.mem_size = BTC_SZ_LONG;
					s_nxt.mem_addr = info_addr(s_r.idx, s_r.wcnt);
				end else if (mem_ack) begin
					s_nxt.mem_req = 1'b0;
					case (s_r.wcnt)
						2'd0: begin
							s_nxt.transfer_mode_a = mem_rdata[31:24];
							s_nxt.source_pointer = mem_rdata[23:0];
						end
						2'd1: begin
							s_nxt.transfer_mode_b = mem_rdata[31:24];
							s_nxt.destination_pointer = mem_rdata[23:0];
						end
						default: begin
							s_nxt.unit_count = mem_rdata[31:16];
							s_nxt.block_count = mem_rdata[15:0];
						end
					endcase
					if (s_r.wcnt == 2'd2) begin
						s_nxt.wcnt = 2'd0;
						s_nxt.blk_start = s_r.transfer_mode_a[BTC_MA_DTS] ?
							s_r.source_pointer : s_r.destination_pointer;
						s_nxt.st = BTC_S_READ;
					end else begin
						s_nxt.wcnt = s_r.wcnt + 2'd1;
					end
				end
			end
			BTC_S_READ: begin
				if (!s_r.mem_req) begin
					s_nxt.mem_req  = 1'b1;
					s_nxt.mem_we   = 1'b0;
					s_nxt.mem_size = word ? BTC_SZ_WORD : BTC_SZ_BYTE;
					s_nxt.mem_addr = s_r.source_pointer;
				end else if (mem_ack) begin
					s_nxt.mem_req = 1'b0;
					s_nxt.data = word ? mem_rdata[15:0] :
						{8'h00, mem_rdata[7:0]};
					s_nxt.st = BTC_S_WRITE;
				end
			end
			BTC_S_WRITE: begin
				if (!s_r.mem_req) begin
					s_nxt.mem_req   = 1'b1;
					s_nxt.mem_we    = 1'b1;
					s_nxt.mem_size  = word ? BTC_SZ_WORD : BTC_SZ_BYTE;
					s_nxt.mem_addr  = s_r.destination_pointer;
					s_nxt.mem_wdata = {16'h0000, s_r.data};
				end else if (mem_ack) begin
					s_nxt.mem_req = 1'b0;
					s_nxt.source_pointer = step_addr(s_r.source_pointer,
						s_r.transfer_mode_a[BTC_MA_SM +: 2], word);
					s_nxt.destination_pointer = step_addr(s_r.destination_pointer,
						s_r.transfer_mode_a[BTC_MA_DM +: 2], word);
					if (s_r.transfer_mode_a[BTC_MA_MD +: 2] == BTC_MD_BLOCK) begin
						if (s_r.unit_count[7:0] == 8'h01) begin
							s_nxt.unit_count[7:0] = s_r.unit_count[15:8];
							if (s_r.transfer_mode_a[BTC_MA_DTS]) begin
								s_nxt.source_pointer = s_r.blk_start;
							end else begin
								s_nxt.destination_pointer = s_r.blk_start;
							end
							s_nxt.block_count = s_r.block_count - 16'h0001;
							sset[BTC_ST_BLK] = 1'b1;
							s_nxt.fin = (s_r.block_count == 16'h0001);
							s_nxt.st  = BTC_S_BACK;
						end else begin
							s_nxt.unit_count[7:0] = s_r.unit_count[7:0] - 8'h01;
							s_nxt.st = BTC_S_READ;
						end
					end else begin
						// Normal mode: one unit per activation
						s_nxt.unit_count = s_r.unit_count - 16'h0001;
						s_nxt.fin = (s_r.unit_count == 16'h0001);
						s_nxt.st  = BTC_S_BACK;
					end
				end
			end
			BTC_S_BACK: begin
				// Write back so the next activation resumes in place
				if (!s_r.mem_req) begin
					s_nxt.mem_req  = 1'b1;
					s_nxt.mem_we   = 1'b1;
					s_nxt.mem_size = BTC_SZ_LONG;
					s_nxt.mem_addr = info_addr(s_r.idx, s_r.wcnt);
					case (s_r.wcnt)
						2'd0:    s_nxt.mem_wdata = {s_r.transfer_mode_a, s_r.source_pointer};
						2'd1:    s_nxt.mem_wdata = {s_r.transfer_mode_b, s_r.destination_pointer};
						default: s_nxt.mem_wdata = {s_r.unit_count, s_r.block_count};
					endcase
					s_nxt.cpu_irq = s_r.fin
						|| s_r.transfer_mode_b[BTC_MB_DISEL];
				end else if (mem_ack) begin
					s_nxt.mem_req = 1'b0;
					if (s_r.wcnt == 2'd2) begin
						s_nxt.wcnt = 2'd0;
						s_nxt.st   = BTC_S_IDLE;
						s_nxt.fin  = 1'b0;
						if (s_r.fin && !s_r.from_sw) begin
							s_nxt.en[s_r.idx] = 1'b0;
						end
						if (s_r.cpu_irq) begin
							sset[BTC_ST_END] = 1'b1;
						end
					end else begin
						s_nxt.wcnt = s_r.wcnt + 2'd1;
					end
				end
			end
			default: begin
				s_nxt.st      = BTC_S_IDLE;
				s_nxt.mem_req = 1'b0;
			end
		endcase

		// ****************************************
		// Bus slave: write path
		// ****************************************
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			rd = reg_read(s_r.awaddr, s_r);
			wv = wmerge(rd[31:0], s_r.wdata, s_r.wstrb);
			s_nxt.bresp = rd[32] ? BTC_RESP_OKAY : BTC_RESP_DECERR;
			case (s_r.awaddr)
				BTC_OFS_CTRL:   s_nxt.stop = wv[BTC_CTRL_STOP];
				BTC_OFS_ENABLE: s_nxt.en = wv[N_SRC-1:0];
				BTC_OFS_SWREQ: begin
					if (wv[BTC_SW_GO]) begin
						s_nxt.sw_pend = 1'b1;
						s_nxt.sw_idx  = wv[IW-1:0];
					end
				end
				BTC_OFS_INT_CLR: s_nxt.status = s_r.status & ~wv[1:0];
				BTC_OFS_INT_EN:  s_nxt.inten = wv[1:0];
				default: ;
			endcase
		end
		// Hardware set wins over a clear in the same cycle
		s_nxt.status = s_nxt.status | sset;
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

		// ****************************************
		// Bus slave: read path
		// ****************************************
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arready) begin
			rd = reg_read(s_axi_araddr, s_r);
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd[31:0];
			s_nxt.rresp  = rd[32] ? BTC_RESP_OKAY : BTC_RESP_DECERR;
		end
		s_nxt.arready = !s_nxt.rvalid;

		s_nxt.irq = |(s_nxt.status & s_nxt.inten);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r         <= '0;
			s_r.st      <= BTC_S_IDLE;
			s_r.stop    <= BTC_STOP_RST;
			s_r.status  <= BTC_STATUS_RST;
			s_r.inten   <= BTC_INTEN_RST;
			s_r.bresp   <= BTC_RESP_OKAY;
			s_r.rresp   <= BTC_RESP_OKAY;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready  = s_r.wready;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign mem_req       = s_r.mem_req;
	assign mem_we        = s_r.mem_we;
	assign mem_size      = s_r.mem_size;
	assign mem_addr      = s_r.mem_addr;
	assign mem_wdata     = s_r.mem_wdata;
	assign irq           = s_r.irq;

endmodule : btc_transfer_controller

// file: sim/btc_tc_asserts.sv
// Port checks of the block transfer controller.
// Assumes one clock and a synchronous active-low reset.
module btc_tc_asserts
	import btc_pkg::*;
#(
	parameter int N_SRC = 8
) (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Register bus
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	// Memory port and interrupt
	input logic        mem_req,
	input logic        mem_we,
	input logic [1:0]  mem_size,
	input logic [23:0] mem_addr,
	input logic        mem_ack,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;

	// ********
	// Helpers
	// ********
	logic [23:0] ack_addr_r;
	logic [1:0]  ack_size_r;
	logic [3:0]  ev_age_r;

	// Age saturates so a stale event never excuses a late rise
	always_ff @(posedge aclk) begin
		if (mem_req && mem_ack) begin
			ack_addr_r <= mem_addr;
			ack_size_r <= mem_size;
		end
		if (!aresetn)
			ev_age_r <= 4'hf;
		else if (s_axi_bvalid || (mem_ack && mem_we))
			ev_age_r <= 4'h0;
		else if (ev_age_r != 4'hf)
			ev_age_r <= ev_age_r + 4'h1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_info_rd;
		mem_req && mem_ack && !mem_we && mem_size == BTC_SZ_LONG;
	endsequence
	sequence s_unit_rd;
		mem_req && mem_ack && !mem_we && mem_size != BTC_SZ_LONG;
	endsequence
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// ********
	// Checks
	// ********
	chk_reset_idle: assert property (disable iff (1'b0)
		!aresetn |=> !mem_req && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
	chk_info_base: assert property (
		mem_req && mem_size == BTC_SZ_LONG
		|-> mem_addr[23:8] == BTC_INFO_BASE[23:8])
		else $error("info access outside table");
	chk_info_order: assert property (
		s_info_rd ##0 (mem_addr[3:2] != 2'h2) |=> !mem_req
		##[1:4] (mem_req && mem_addr == ack_addr_r + 24'h4))
		else $error("info words out of order");
	chk_unit_pair: assert property (
		s_unit_rd |=> !mem_req
		##[1:4] (mem_req && mem_we && mem_size == ack_size_r))
		else $error("unit read not followed by write");
	chk_req_hold: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_size))
		else $error("memory request changed before ack");
	chk_wr_answer: assert property (
		s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	chk_b_done: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	chk_r_done: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	chk_irq_cause: assert property (
		$rose(irq) |-> ev_age_r <= 4'h6)
		else $error("interrupt rose without cause");
endmodule : btc_tc_asserts

bind btc_transfer_controller btc_tc_asserts #(.N_SRC(N_SRC)) u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we,
	.mem_size, .mem_addr, .mem_ack, .irq);

// file: sim/btc_mem_model.sv
// System memory model on the controller's memory port.
// Assumes one access at a time; big-endian byte storage.
module btc_mem_model (
	// Clock
	input  logic        aclk,
	// Memory port
	input  logic        mem_req,
	input  logic        mem_we,
	input  logic [1:0]  mem_size,
	input  logic [23:0] mem_addr,
	input  logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic        mem_ack,
	// Answer delay in cycles
	input  logic [3:0]  lat
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0]  m [int];
	int          wait_cnt = 0;
	int          n;
	logic [31:0] w;

	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
	end

	always @(posedge aclk) begin
		n = (mem_size == 2'b10) ? 4 : (mem_size == 2'b01) ? 2 : 1;
		mem_ack <= 1'b0;
		// Idle data lines toggle so no old value is trusted
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_cnt < lat)
				wait_cnt <= wait_cnt + 1;
			else begin
				wait_cnt <= 0;
				mem_ack <= 1'b1;
				w = 32'h0;
				for (int i = 0; i < n; i++) begin
					if (mem_we)
						m[mem_addr + i] = mem_wdata[8*(n-1-i) +: 8];
					w = {w[23:0], m.exists(mem_addr + i) ? m[mem_addr + i] : 8'h0};
				end
				mem_rdata <= w;
			end
		end
	end
endmodule : btc_mem_model

// file: sim/btc_transfer_controller_tb.sv
// Self-checking bench of the block transfer controller.
// Assumes the memory model answers every memory access.
module btc_transfer_controller_tb
	import btc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  ext_req = 8'hff;
	logic [7:0]  awaddr = 8'h0;
	logic [7:0]  araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic        mreq, mwe, mack;
	logic [1:0]  bresp, rresp, msize;
	logic [23:0] maddr;
	logic [31:0] rdata, mwdata, mrdata;
	logic [31:0] seed = 32'hdc15bd20;
	logic [3:0]  lat = 4'h0;
	int          failures = 0, check_count = 0, cyc = 0;
	logic [33:0] bq[$], rq[$];
	logic [57:0] wq[$];

	initial forever #25 aclk = ~aclk;

	btc_transfer_controller #(.N_SRC(8)) DUT (
		.aclk(aclk), .aresetn(aresetn), .ext_req(ext_req),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mreq),
		.mem_we(mwe), .mem_size(msize), .mem_addr(maddr),
		.mem_wdata(mwdata), .mem_rdata(mrdata), .mem_ack(mack), .irq(irq));

	btc_mem_model MEM (
		.aclk(aclk), .mem_req(mreq), .mem_we(mwe), .mem_size(msize),
		.mem_addr(maddr), .mem_wdata(mwdata), .mem_rdata(mrdata),
		.mem_ack(mack), .lat(lat));

	// ********
	// Helpers
	// ********
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	task automatic results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	task automatic note(input logic [63:0] g, e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask : note

	task automatic cmp_rd(input logic [33:0] g, e);
		note({30'h0, g}, {30'h0, e});
	endtask : cmp_rd

	task automatic cmp_mw(input logic [57:0] g, e);
		note({6'h0, g}, {6'h0, e});
	endtask : cmp_mw

	task automatic cmp_lvl(input logic g, e);
		note({63'h0, g}, {63'h0, e});
	endtask : cmp_lvl

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back({r, 32'h0});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b0;
		end while (awvalid || wvalid || bready);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		rq.push_back({r, e});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b0;
		end while (arvalid || rready);
	endtask : rd

	task automatic ew(input logic [23:0] a, input logic [1:0] s,
		input logic [31:0] d);
		wq.push_back({a, s, d});
	endtask : ew

	task automatic poke(input logic [23:0] a, input logic [31:0] d);
		for (int i = 0; i < 4; i++) MEM.m[a + i] = d[31 - 8*i -: 8];
	endtask : poke

	// Block area is the destination: it restarts at 200 every block
	task automatic blk(input int k, input logic [15:0] left);
		logic [23:0] s;
		for (int i = 0; i < 3; i++) begin
			s = 24'h100 + 24'(6*k + 2*i);
			ew(24'h200 + 24'(2*i), BTC_SZ_WORD, {16'h0, MEM.m[s], MEM.m[s + 1]});
		end
		ew(BTC_INFO_BASE, BTC_SZ_LONG, {8'ha9, 24'h100 + 24'(6*k + 6)});
		ew(BTC_INFO_BASE + 24'h4, BTC_SZ_LONG, 32'h200);
		ew(BTC_INFO_BASE + 24'h8, BTC_SZ_LONG, {16'h0303, left});
	endtask : blk

	task automatic pulse;
		@(posedge aclk);
		ext_req[0] <= 1'b0;
		repeat (2) @(posedge aclk);
		ext_req[0] <= 1'b1;
	endtask : pulse

	task automatic drain;
		while (wq.size() != 0) @(posedge aclk);
		repeat (3) @(posedge aclk);
	endtask : drain

	// ********
	// Monitor
	// ********
	always @(posedge aclk) begin
		logic [31:0] d;
		cyc++;
		if (cyc == 20000) begin
			failures++;
			results;
		end
		if (bvalid && bready) cmp_rd({bresp, 32'h0}, bq.pop_front());
		if (rvalid && rready) cmp_rd({rresp, rdata}, rq.pop_front());
		if (mreq && mack && mwe) begin
			d = msize == BTC_SZ_LONG ? mwdata : msize == BTC_SZ_WORD
				? {16'h0, mwdata[15:0]} : {24'h0, mwdata[7:0]};
			cmp_mw({maddr, msize, d}, wq.size() ? wq.pop_front() : '1);
		end
	end

	// ********
	// Sequence
	// ********
	initial begin
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			MEM.m[24'h100 + i] = seed[7:0];
		end
		MEM.m[24'h300] = seed[15:8];
		poke(BTC_INFO_BASE, {8'ha9, 24'h100});
		poke(BTC_INFO_BASE + 24'h4, 32'h200);
		poke(BTC_INFO_BASE + 24'h8, 32'h0303_0002);
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(BTC_OFS_CTRL, 32'h1, BTC_RESP_OKAY);
		rd(BTC_OFS_ENABLE, 32'h0, BTC_RESP_OKAY);
		rd(8'h40, 32'h0, BTC_RESP_DECERR);
		wr(8'h40, 32'hff, BTC_RESP_DECERR);
		wr(BTC_OFS_ENABLE, 32'h1, BTC_RESP_OKAY);
		wr(BTC_OFS_INT_EN, 32'h1, BTC_RESP_OKAY);
		pulse;
		// Still stopped: no write may appear yet
		repeat (40) @(posedge aclk);
		blk(0, 16'h1);
		wr(BTC_OFS_CTRL, 32'h0, BTC_RESP_OKAY);
		drain;
		cmp_lvl(irq, 1'b0);
		lat <= seed[3:0] | 4'h4;
		blk(1, 16'h0);
		pulse;
		drain;
		cmp_lvl(irq, 1'b1);
		rd(BTC_OFS_ENABLE, 32'h0, BTC_RESP_OKAY);
		pulse;
		repeat (40) @(posedge aclk);
		wr(BTC_OFS_INT_EN, 32'h0, BTC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		cmp_lvl(irq, 1'b0);
		wr(BTC_OFS_INT_EN, 32'h1, BTC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		cmp_lvl(irq, 1'b1);
		wr(BTC_OFS_INT_CLR, 32'h3, BTC_RESP_OKAY);
		wr(BTC_OFS_STATUS, 32'h3, BTC_RESP_OKAY);
		rd(BTC_OFS_STATUS, 32'h0, BTC_RESP_OKAY);
		cmp_lvl(irq, 1'b0);
		// Destination steps down to cover the decrement mode
		poke(BTC_INFO_BASE + 24'h10, {8'hb0, 24'h300});
		poke(BTC_INFO_BASE + 24'h14, {8'h40, 24'h400});
		poke(BTC_INFO_BASE + 24'h18, 32'h0001_0000);
		ew(24'h400, BTC_SZ_BYTE, {24'h0, MEM.m[24'h300]});
		ew(BTC_INFO_BASE + 24'h10, BTC_SZ_LONG, {8'hb0, 24'h301});
		ew(BTC_INFO_BASE + 24'h14, BTC_SZ_LONG, {8'h40, 24'h3ff});
		ew(BTC_INFO_BASE + 24'h18, BTC_SZ_LONG, 32'h0);
		wr(BTC_OFS_SWREQ, 32'h81, BTC_RESP_OKAY);
		drain;
		cmp_lvl(irq, 1'b1);
		rd(BTC_OFS_STATUS, 32'h1, BTC_RESP_OKAY);
		rd(BTC_OFS_INT_EN, 32'h1, BTC_RESP_OKAY);
		rd(BTC_OFS_SWREQ, 32'h1, BTC_RESP_OKAY);
		rd(BTC_OFS_STATE, 32'h108, BTC_RESP_OKAY);
		results;
	end
endmodule : btc_transfer_controller_tb
